/* pkg/dgp_cfg.svh */
// register indices, field positions, reset values for the dual gpio port block
`ifndef DGP_CFG_SVH
`define DGP_CFG_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define DGP_IDX_OPTION      8'h81
`define DGP_IDX_PB_DIR      8'h86
`define DGP_IDX_PB_DATA     8'h06
`define DGP_IDX_PC_DATA     8'h07
`define DGP_IDX_PC_DIR      8'h87
`define DGP_IDX_ICTL        8'h0B
`define DGP_IDX_SSP         8'h94

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DGP_OPT_PU_N_BIT    7
`define DGP_ICTL_CHG_BIT    0
`define DGP_ICTL_EXT_BIT    1
`define DGP_SSP_I2C_EN_BIT  0
`define DGP_SSP_SMBUS_BIT   6
`define DGP_WATCH_MASK      8'hF0
`define DGP_EXT_PIN_BIT     0
`define DGP_LVP_PGM_BIT     3
`define DGP_LVP_CLK_BIT     6
`define DGP_LVP_DAT_BIT     7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DGP_RST_OPTION      8'hFF
`define DGP_RST_DIR         8'hFF
`define DGP_RST_LATCH       8'h00
`define DGP_RST_SSP         8'h00

`endif

/* pkg/dgp_pkg.sv */
// types shared by the dual gpio port block
package dgp_pkg;

    // one 8-bit pad group as seen by the pad ring
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } dgp_pad_t;

    // all state of the block
    typedef struct packed {
        logic [7:0]  pb_s1;
        logic [7:0]  pb_s2;
        logic [7:0]  pc_s1;
        logic [7:0]  pc_s2;
        logic [7:0]  pb_lat;
        logic [7:0]  pb_dir;
        logic [7:0]  pc_lat;
        logic [7:0]  pc_dir;
        logic [7:0]  opt;
        logic [7:0]  ssp;
        logic [7:0]  pb_ref;
        logic        chg_flag;
        logic        ext_flag;
        logic        ext_prev;
        logic        wr_pend;
        logic [7:0]  wr_idx;
        logic [31:0] rdata;
    } dgp_state_t;

endpackage : dgp_pkg

/* hw/dgp_top.sv */
// dual 8-bit gpio ports with pin-change flag, peripheral overrides, ahb-lite registers
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "dgp_cfg.svh"

module dgp_top
    import dgp_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_por,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    // second port pads
    input  wire logic [7:0]  i_pb_pin,
    output dgp_pad_t         o_pb_pad,
    // programming / debug mode on second port
    input  wire logic        i_lvp_active,
    input  wire logic        i_prog_data_out,
    input  wire logic        i_prog_data_oe,
    output logic [7:0]       o_pb_pin_sync,
    // interrupt and sleep
    input  wire logic        i_sleep,
    output logic             o_pin_change_flag,
    output logic             o_ext_int_flag,
    output logic             o_wake,
    // third port pads
    input  wire logic [7:0]  i_pc_pin,
    output dgp_pad_t         o_pc_pad,
    output logic             o_pc_smbus_lvl,
    // third port peripheral overrides
    input  wire logic [7:0]  i_periph_sel,
    input  wire logic [7:0]  i_periph_out,
    input  wire logic [7:0]  i_periph_oe,
    output logic [7:0]       o_pc_pin_sync,
    output logic             o_uart_rx,
    output logic             o_uart_ck_in
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [7:0] read_mux(input logic [7:0] idx, input dgp_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `DGP_IDX_OPTION:  v = s.opt;
            `DGP_IDX_PB_DIR:  v = s.pb_dir;
            `DGP_IDX_PB_DATA: v = s.pb_s2;
            `DGP_IDX_PC_DATA: v = s.pc_s2;
            `DGP_IDX_PC_DIR:  v = s.pc_dir;
            `DGP_IDX_ICTL:    v = {6'h00, s.ext_flag, s.chg_flag};
            `DGP_IDX_SSP:     v = s.ssp;
            default:          v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    // watched inputs that no longer match the reference taken at the last access
    function automatic logic [7:0] watch_diff(input dgp_state_t s);
        return (s.pb_s2 ^ s.pb_ref) & s.pb_dir & `DGP_WATCH_MASK;
    endfunction : watch_diff

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    dgp_state_t st_r;
    dgp_state_t st_nxt;

    logic       acc;
    logic [7:0] acc_idx;
    logic       rd_pb;
    logic       wr_pb;
    logic [7:0] mismatch;
    logic       chg_any;
    logic       wr_ictl;
    logic [7:0] wb;

    // an address outside the word-aligned low window decodes as unmapped
    assign acc     = i_hsel && i_htrans[1] && i_hready;
    assign acc_idx = (i_haddr[31:10] == 22'h000000 && i_haddr[1:0] == 2'h0)
                     ? i_haddr[9:2] : 8'hFF;
    assign rd_pb   = acc && !i_hwrite && (acc_idx == `DGP_IDX_PB_DATA);
    assign wr_pb   = st_r.wr_pend && (st_r.wr_idx == `DGP_IDX_PB_DATA);
    assign wr_ictl = st_r.wr_pend && (st_r.wr_idx == `DGP_IDX_ICTL);
    assign wb      = i_hwdata[7:0];

    // outputs and pins 0 to 3 are never compared; programming-owned pins 6 and 7 still are
    assign mismatch = watch_diff(st_r);
    assign chg_any  = |mismatch;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // two-flop pin synchronisers
        st_nxt.pb_s1 = i_pb_pin;
        st_nxt.pb_s2 = st_r.pb_s1;
        st_nxt.pc_s1 = i_pc_pin;
        st_nxt.pc_s2 = st_r.pc_s1;

        // address phase
        st_nxt.wr_pend = acc && i_hwrite;
        st_nxt.wr_idx  = acc_idx;
        if (acc && !i_hwrite) begin
            st_nxt.rdata = {24'h000000, read_mux(acc_idx, st_r)};
        end

        // data phase writes: latch only, whatever the direction
        if (st_r.wr_pend) begin
            case (st_r.wr_idx)
                `DGP_IDX_OPTION:  st_nxt.opt    = wb;
                `DGP_IDX_PB_DIR:  st_nxt.pb_dir = wb;
                `DGP_IDX_PB_DATA: st_nxt.pb_lat = wb;
                `DGP_IDX_PC_DATA: st_nxt.pc_lat = wb;
                `DGP_IDX_PC_DIR:  st_nxt.pc_dir = wb;
                `DGP_IDX_SSP:     st_nxt.ssp    = wb;
                default:          st_nxt.pc_dir = st_r.pc_dir;
            endcase
        end

        // reading or writing the data register ends the mismatch
        if (rd_pb || wr_pb) begin
            st_nxt.pb_ref = st_r.pb_s2;
        end

        // flags: software clears by writing zero, a live event wins
        if (wr_ictl && !wb[`DGP_ICTL_CHG_BIT]) begin
            st_nxt.chg_flag = 1'b0;
        end
        if (chg_any) begin
            st_nxt.chg_flag = 1'b1;
        end
        st_nxt.ext_prev = st_r.pb_s2[`DGP_EXT_PIN_BIT];
        if (wr_ictl && !wb[`DGP_ICTL_EXT_BIT]) begin
            st_nxt.ext_flag = 1'b0;
        end
        if (st_r.pb_s2[`DGP_EXT_PIN_BIT] && !st_r.ext_prev) begin
            st_nxt.ext_flag = 1'b1;
        end

        // synchronous reset; the data latches survive all but power-on
        if (!i_rst_n) begin
            st_nxt.opt      = `DGP_RST_OPTION;
            st_nxt.pb_dir   = `DGP_RST_DIR;
            st_nxt.pc_dir   = `DGP_RST_DIR;
            st_nxt.ssp      = `DGP_RST_SSP;
            st_nxt.chg_flag = 1'b0;
            st_nxt.ext_flag = 1'b0;
            st_nxt.wr_pend  = 1'b0;
            st_nxt.rdata    = 32'h00000000;
            st_nxt.pb_ref   = st_r.pb_s2;
            // a write landing in the reset cycle must not disturb a kept latch
            st_nxt.pb_lat   = st_r.pb_lat;
            st_nxt.pc_lat   = st_r.pc_lat;
            if (i_por) begin
                st_nxt.pb_lat = `DGP_RST_LATCH;
                st_nxt.pc_lat = `DGP_RST_LATCH;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------------------
    // bus answer: zero wait states, always okay
    // ------------------------------------------------------------------------
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = st_r.rdata;

    // ------------------------------------------------------------------------
    // second port pads
    // ------------------------------------------------------------------------
    logic [7:0] pb_out;
    logic [7:0] pb_oe;

    always_comb begin
        pb_out = st_r.pb_lat;
        pb_oe  = ~st_r.pb_dir;
        // programming mode owns pgm (input only), clock (input) and data
        if (i_lvp_active) begin
            pb_oe[`DGP_LVP_PGM_BIT]  = 1'b0;
            pb_oe[`DGP_LVP_CLK_BIT]  = 1'b0;
            pb_oe[`DGP_LVP_DAT_BIT]  = i_prog_data_oe;
            pb_out[`DGP_LVP_DAT_BIT] = i_prog_data_out;
        end
    end

    assign o_pb_pad.out = pb_out;
    assign o_pb_pad.oe  = pb_oe;
    // pull-up is cut on any pin that is being driven
    assign o_pb_pad.pu  = {8{~st_r.opt[`DGP_OPT_PU_N_BIT]}} & ~pb_oe;
    assign o_pb_pin_sync = st_r.pb_s2;

    // ------------------------------------------------------------------------
    // flags and wake
    // ------------------------------------------------------------------------
    assign o_pin_change_flag = st_r.chg_flag;
    assign o_ext_int_flag    = st_r.ext_flag;
    assign o_wake            = i_sleep && st_r.chg_flag;

    // ------------------------------------------------------------------------
    // third port pads
    // ------------------------------------------------------------------------
    // a selected peripheral owns both data and enable; its oe can force either way
    assign o_pc_pad.out = (i_periph_sel & i_periph_out) | (~i_periph_sel & st_r.pc_lat);
    assign o_pc_pad.oe  = (i_periph_sel & i_periph_oe)
                        | (~i_periph_sel & ~st_r.pc_dir);
    assign o_pc_pad.pu  = 8'h00;
    assign o_pc_smbus_lvl = st_r.ssp[`DGP_SSP_I2C_EN_BIT]
                          && st_r.ssp[`DGP_SSP_SMBUS_BIT];
    assign o_pc_pin_sync = st_r.pc_s2;
    assign o_uart_rx     = st_r.pc_s2[7];
    assign o_uart_ck_in  = st_r.pc_s2[6];

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    sequence seq_pb_read;
        acc && !i_hwrite && (acc_idx == `DGP_IDX_PB_DATA);
    endsequence

    sequence seq_clear_under_mismatch;
        wr_ictl && !wb[`DGP_ICTL_CHG_BIT] && chg_any;
    endsequence

    pb_dir_drive_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_lvp_active |-> (o_pb_pad.oe == ~st_r.pb_dir)
                          && ((o_pb_pad.out & o_pb_pad.oe) == (st_r.pb_lat & ~st_r.pb_dir)))
        else $error("second port drive does not follow direction");

    pullup_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_lvp_active |-> (o_pb_pad.pu == ({8{~st_r.opt[7]}} & st_r.pb_dir)))
        else $error("pull-up not gated by control bit and direction");

    por_pullup_a: assert property (@(posedge i_ref_clk)
        (!i_rst_n && i_por) |=> (o_pb_pad.pu == 8'h00) && (st_r.pb_lat == 8'h00))
        else $error("pull-ups or latch not cleared by power-on reset");

    reset_dir_a: assert property (@(posedge i_ref_clk)
        (!i_rst_n && !i_por) |=> (st_r.pb_dir == 8'hFF) && (st_r.pc_dir == 8'hFF)
                                 && (st_r.pb_lat == $past(st_r.pb_lat)))
        else $error("warm reset broke direction or latch");

    change_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (|((st_r.pb_s2 ^ st_r.pb_ref) & st_r.pb_dir & 8'hF0)) |=> o_pin_change_flag)
        else $error("watched mismatch did not raise change flag");

    change_sticky_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        seq_clear_under_mismatch |=> o_pin_change_flag)
        else $error("change flag cleared while mismatch persisted");

    ref_refresh_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        seq_pb_read |=> (st_r.pb_ref == $past(st_r.pb_s2))
                        && (!(|mismatch) || $changed(st_r.pb_s2)))
        else $error("data read did not refresh compare reference");

    output_exclude_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (st_r.pb_dir[7:4] == 4'h0) |-> !chg_any)
        else $error("output pin took part in change compare");

    wake_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_sleep && o_pin_change_flag) |-> o_wake)
        else $error("change flag did not wake from sleep");

    periph_oe_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_periph_sel == 8'h00) |-> (o_pc_pad.oe == ~st_r.pc_dir) && (o_pc_pad.out == st_r.pc_lat))
        else $error("peripheral oe leaked without select");

    latch_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_pb && st_r.pb_dir[0]) |=> (st_r.pb_lat == $past(wb)) && !o_pb_pad.oe[0])
        else $error("write to input pin lost or drove it");

    smbus_lvl_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !st_r.ssp[0] |-> !o_pc_smbus_lvl)
        else $error("smbus level active without i2c enable");

    // ------------------------------------------------------------------------
    // access, flag and pad-path checks
    // ------------------------------------------------------------------------
    sequence seq_pb_write;
        st_r.wr_pend && (st_r.wr_idx == `DGP_IDX_PB_DATA);
    endsequence

    sequence seq_ext_rise;
        st_r.pb_s2[`DGP_EXT_PIN_BIT] && !st_r.ext_prev;
    endsequence

    sequence seq_clear_quiet;
        wr_ictl && !wb[`DGP_ICTL_CHG_BIT] && !chg_any;
    endsequence

    pin_readback_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        seq_pb_read |=> (o_hrdata == {24'h000000, $past(st_r.pb_s2)}))
        else $error("data read did not return the synchronised pins");

    data_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        seq_pb_write |=> (st_r.pb_lat == $past(wb)) && (st_r.pb_ref == $past(st_r.pb_s2)))
        else $error("data write missed latch or reference");

    flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        seq_clear_quiet |=> !o_pin_change_flag)
        else $error("change flag not cleared once mismatch ended");

    ext_rise_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        seq_ext_rise |=> o_ext_int_flag)
        else $error("rising edge on bit 0 did not set external flag");

    pb_sync_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_pb_pin_sync == $past(i_pb_pin, 2))
        else $error("second port pins not seen two edges later");

    lvp_pins_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_lvp_active |-> !o_pb_pad.oe[3] && !o_pb_pad.oe[6]
                         && (o_pb_pad.oe[7] == i_prog_data_oe))
        else $error("programming mode pins not handed over");

    driven_no_pull_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !(|(o_pb_pad.pu & o_pb_pad.oe)))
        else $error("pull-up left on a driven pin");

    reset_flags_a: assert property (@(posedge i_ref_clk)
        !i_rst_n |=> !o_pin_change_flag && !o_ext_int_flag && (st_r.opt == 8'hFF))
        else $error("reset left a flag or pull-up control set");

    pc_select_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ((o_pc_pad.oe & i_periph_sel) == (i_periph_oe & i_periph_sel))
        && ((o_pc_pad.oe & ~i_periph_sel) == (~st_r.pc_dir & ~i_periph_sel)))
        else $error("third port enable not chosen by select");

    pc_sync_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_pc_pin_sync == $past(i_pc_pin, 2)) && (o_uart_rx == $past(i_pc_pin[7], 2))
        && (o_uart_ck_in == $past(i_pc_pin[6], 2)))
        else $error("third port or uart pins not seen two edges later");

    smbus_sel_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (st_r.ssp[`DGP_SSP_I2C_EN_BIT] && st_r.ssp[`DGP_SSP_SMBUS_BIT]) |-> o_pc_smbus_lvl)
        else $error("smbus levels not selected");

endmodule : dgp_top

/* bench/dgp_pin_model.sv */
// pin model: pad drive, external drive, pull-up and floating lines
`timescale 1ns/1ps
module dgp_pin_model
    import dgp_pkg::*;
(
    // clock
    input  wire logic       i_ref_clk,
    // pad side
    input  wire dgp_pad_t   i_pad,
    // far side drivers
    input  wire logic [7:0] i_ext_val,
    input  wire logic [7:0] i_ext_en,
    output logic [7:0]      o_pin
);
    // ------------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------------
    // a released line with no pull flips every cycle, never a stale level
    logic [7:0] flt_r = 8'h00;
    always @(posedge i_ref_clk) begin
        flt_r <= ~flt_r;
    end
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (i_pad.oe[b])
                o_pin[b] = i_pad.out[b];
            else if (i_ext_en[b])
                o_pin[b] = i_ext_val[b];
            else if (i_pad.pu[b])
                o_pin[b] = 1'b1;
            else
                o_pin[b] = flt_r[b];
        end
    end
endmodule : dgp_pin_model

/* bench/testbench.sv */
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
`include "dgp_cfg.svh"
module testbench
    import dgp_pkg::*;
;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        por = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  pb_val = 8'h00, pb_en = 8'hFF;
    logic [7:0]  pc_val = 8'h00, pc_en = 8'hFF;
    logic [7:0]  psel = 8'h00, pout = 8'h00, poe = 8'h00;
    logic        lvp = 1'b0, pdo = 1'b0, pdoe = 1'b0, slp = 1'b0;
    logic        hrdy, hresp, chg, extf, wake, smb, urx, uck;
    logic [31:0] hrdata, rd;
    logic [7:0]  pb_pin, pc_pin, pb_sync, pc_sync;
    dgp_pad_t    pb_pad, pc_pad;
    int          err_count = 0, check_count = 0, cyc = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    dgp_top uut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_por(por), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_pb_pin(pb_pin), .o_pb_pad(pb_pad),
        .i_lvp_active(lvp), .i_prog_data_out(pdo), .i_prog_data_oe(pdoe),
        .o_pb_pin_sync(pb_sync), .i_sleep(slp), .o_pin_change_flag(chg),
        .o_ext_int_flag(extf), .o_wake(wake), .i_pc_pin(pc_pin),
        .o_pc_pad(pc_pad), .o_pc_smbus_lvl(smb), .i_periph_sel(psel),
        .i_periph_out(pout), .i_periph_oe(poe), .o_pc_pin_sync(pc_sync),
        .o_uart_rx(urx), .o_uart_ck_in(uck));
    dgp_pin_model pbm (.i_ref_clk(clk), .i_pad(pb_pad), .i_ext_val(pb_val),
        .i_ext_en(pb_en), .o_pin(pb_pin));
    dgp_pin_model pcm (.i_ref_clk(clk), .i_pad(pc_pad), .i_ext_val(pc_val),
        .i_ext_en(pc_en), .o_pin(pc_pin));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_rdy();
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
    endtask : wait_rdy

    // one single word transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
        @(negedge clk);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rd[7:0], exp);
    endtask : rdc

    // synchroniser takes two edges, the flag one more
    task automatic pins(input logic [7:0] v, input logic [7:0] e);
        @(posedge clk);
        pb_val <= v;
        pb_en  <= e;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : pins

    task automatic rst(input logic p);
        @(posedge clk);
        rst_n <= 1'b0;
        por   <= p;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        por   <= 1'b0;
        @(negedge clk);
    endtask : rst

    // the run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        rst(1'b1);
        check(pb_pad.oe, 8'h00);
        check(pb_pad.pu, 8'h00);
        rdc(`DGP_IDX_OPTION, 8'hFF);
        rdc(`DGP_IDX_PB_DIR, 8'hFF);
        rdc(`DGP_IDX_PC_DIR, 8'hFF);
        rdc(8'h55, 8'h00);
        check(8'(hresp), 8'h00);
        $display("reset test done");
        pins(8'h03, 8'h0F);
        wr(`DGP_IDX_PB_DATA, 8'hA5);
        check(pb_pad.oe, 8'h00);
        wr(`DGP_IDX_PB_DIR, 8'h0F);
        check(pb_pad.oe, 8'hF0);
        check(pb_pad.out, 8'hA5);
        pins(8'h03, 8'h0F);
        rdc(`DGP_IDX_PB_DATA, 8'hA3);
        wr(`DGP_IDX_OPTION, 8'h7F);
        check(pb_pad.pu, 8'h0F);
        wr(`DGP_IDX_OPTION, 8'hFF);
        check(pb_pad.pu, 8'h00);
        $display("direction test done");
        wr(`DGP_IDX_PB_DIR, 8'hFF);
        pins(8'h00, 8'hFF);
        rdc(`DGP_IDX_PB_DATA, 8'h00);           // one read only, to arm
        wr(`DGP_IDX_ICTL, 8'h00);
        rdc(`DGP_IDX_ICTL, 8'h00);
        pins(8'h20, 8'hFF);
        rdc(`DGP_IDX_ICTL, 8'h01);
        check(8'(chg), 8'h01);
        @(posedge clk);
        slp <= 1'b1;
        @(negedge clk);
        check(8'(wake), 8'h01);
        wr(`DGP_IDX_ICTL, 8'h00);
        rdc(`DGP_IDX_ICTL, 8'h01);
        rdc(`DGP_IDX_PB_DATA, 8'h20);
        wr(`DGP_IDX_ICTL, 8'h00);
        rdc(`DGP_IDX_ICTL, 8'h00);
        pins(8'h24, 8'hFF);
        rdc(`DGP_IDX_ICTL, 8'h00);
        wr(`DGP_IDX_PB_DIR, 8'hEF);
        pins(8'h24, 8'hEF);
        wr(`DGP_IDX_PB_DATA, 8'h10);
        pins(8'h25, 8'hEF);
        rdc(`DGP_IDX_ICTL, 8'h02);
        check(8'(extf), 8'h01);
        check(pb_sync, 8'h35);
        $display("change test done");
        @(posedge clk);
        lvp   <= 1'b1;
        pdo   <= 1'b1;
        pdoe  <= 1'b1;
        pb_en <= 8'h48;
        wr(`DGP_IDX_PB_DIR, 8'h00);
        check(pb_pad.oe, 8'hB7);
        check(8'(pb_pad.out[7]), 8'h01);
        @(posedge clk);
        lvp <= 1'b0;
        @(negedge clk);
        check(pb_pad.oe, 8'hFF);
        wr(`DGP_IDX_PB_DATA, 8'h3C);
        rst(1'b0);
        check(pb_pad.oe, 8'h00);
        wr(`DGP_IDX_PB_DIR, 8'h00);
        check(pb_pad.out, 8'h3C);
        $display("program and reset test done");
        @(posedge clk);
        pc_en <= 8'h00;
        wr(`DGP_IDX_PC_DIR, 8'h00);             // whole value, no read-modify-write
        wr(`DGP_IDX_PC_DATA, 8'h5A);
        check(pc_pad.oe, 8'hFF);
        check(pc_pad.out, 8'h5A);
        @(posedge clk);
        psel <= 8'hF0;
        pout <= 8'hC0;
        poe  <= 8'h30;
        @(negedge clk);
        check(pc_pad.oe, 8'h3F);
        check(pc_pad.out, 8'hCA);
        check(pc_pad.pu, 8'h00);
        @(posedge clk);
        psel   <= 8'h00;
        pc_en  <= 8'hFF;
        pc_val <= 8'h80;
        wr(`DGP_IDX_PC_DIR, 8'hFF);
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(8'(urx), 8'h01);
        check(8'(uck), 8'h00);
        check(pc_sync, 8'h80);
        wr(`DGP_IDX_SSP, 8'h41);
        check(8'(smb), 8'h01);
        wr(`DGP_IDX_SSP, 8'h01);
        check(8'(smb), 8'h00);
        $display("third port test done");
        print_verdict();
    end
endmodule : testbench
